// ===== rtl/ee_slave_top.sv
// Two-wire memory slave front end with write-cycle lockout.
//
// How it works
// R1: The first byte after a start is the address.
// R2: A foreign type code leaves the device unselected.
// R3: Address bits 3 and 2 must match the straps.
// R4: Address bit 1 picks one of two 256-byte blocks.
// R5: Direction 1 is a read, 0 a write.
// R6: A receiver holds data low in the ninth clock.
// R7: A sender releases data after eight bits.
// R8: Each byte is acked unless the receiver ends.
// R9: The master frames each transfer with start and stop.
// R10: The master sends the address, then the array address.
// R11: A stop after a write starts a 10 ms or 15 ms cycle.
// R12: The write cycle leaves the bus deaf and data released.
// R13: Pulses under 100 ns, or 50 ns fast, are dropped.
// R14: Data falling with clock high starts, rising stops.
// R15: Nothing is acked before a start; address and writes are.
// R16: The byte after the address is the array address.
// R17: A mismatch idles with data released until a start.
`timescale 1ns/100ps
module ee_slave_top import ee_pkg::*; #(
  parameter logic [3:0]  TYPE_CODE    = 4'h5,          // Arbitrary value.
  parameter int unsigned WR_HI_CYCLES = WRCYC_HI_CYC,
  parameter int unsigned WR_LO_CYCLES = WRCYC_LO_CYC,
  parameter int          FIFO_W       = WORD_W,
  parameter int          FIFO_D       = FIFO_DEPTH
)(
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         linkClk,
  input  wire logic         sclPin,
  input  wire logic         sdaPin,
  input  wire logic         strapSelectLow,
  input  wire logic         strapSelectHigh,
  input  wire logic         fastModePin,
  input  wire logic         lowSupplyPin,
  input  wire logic [7:0]   readData,
  output logic              sdaOut,
  output logic              sdaOe,
  output logic              writeCycleBusy,
  output logic              readStrobe,
  output logic              linkValid,
  input  wire logic         linkReady,
  output logic [FIFO_W-1:0] linkData
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  ee_state_e               state_r;
  logic [3:0]              pinMeta_r, pinSync_r;
  logic                    sclF, sdaF, sclPrev_r, sdaPrev_r;
  logic                    sclRise, sclFall, startDet, stopDet, busActive;
  logic [7:0]              rxReg_r, txReg_r;
  logic [3:0]              bitCnt_r;
  logic                    addrPhase_r, rwRead_r, firstByte_r, blockSel_r, writeSeen_r;
  logic                    sdaOe_r, sdaOut_r, readStrobe_r, busy_r, commitPend_r;
  logic [WR_TIMER_W-1:0]   wrTimer_r;
  logic                    byteDone, byteStore, loadTx, commitGo;
  logic                    linkRst1_r, linkRst2_r;

  ee_push_if #(.W(FIFO_W)) pushCh ();

  assign sdaOut         = sdaOut_r;
  assign sdaOe          = sdaOe_r;
  assign writeCycleBusy = busy_r;
  assign readStrobe     = readStrobe_r;

  // Type and strap bits must match; the block bit takes no part.
  function automatic logic addrMatch(input logic [7:0] a, input logic hi, input logic lo);
    return (a[TYPE_MSB:TYPE_LSB] == TYPE_CODE) && (a[SEL_HIGH_BIT] == hi) &&
           (a[SEL_LOW_BIT] == lo);
  endfunction

  // ==========================================================================
  // Pin synchronisers and input filters
  // ==========================================================================
  // Quasi-static pins still cross into mclk on two flops.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
    end else begin
      pinMeta_r <= {lowSupplyPin, fastModePin, strapSelectHigh, strapSelectLow};
      pinSync_r <= pinMeta_r;
    end
  end

  ee_glitch_filter uSclFilt (
    .clk      (mclk),
    .rstn     (rstn),
    .pinIn    (sclPin),
    .fastMode (pinSync_r[2]),
    .lvl_r    (sclF)
  );

  ee_glitch_filter uSdaFilt (
    .clk      (mclk),
    .rstn     (rstn),
    .pinIn    (sdaPin),
    .fastMode (pinSync_r[2]),
    .lvl_r    (sdaF)
  );

  // ==========================================================================
  // Bus condition detection
  // ==========================================================================
  // Filtered edges; data moving while clock is high is a condition.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclPrev_r <= BUS_IDLE_LVL;
      sdaPrev_r <= BUS_IDLE_LVL;
    end else begin
      sclPrev_r <= sclF;
      sdaPrev_r <= sdaF;
    end
  end

  assign sclRise  = sclF & ~sclPrev_r;
  assign sclFall  = ~sclF & sclPrev_r;
  assign startDet = sclF & sclPrev_r & sdaPrev_r & ~sdaF;   // [R14]
  assign stopDet  = sclF & sclPrev_r & ~sdaPrev_r & sdaF;   // [R14]
  // Conditions and the write cycle hold the byte engine.
  assign busActive = ~busy_r & ~startDet & ~stopDet;        // [R12]

  assign byteDone  = busActive && (state_r == ST_RECV) && sclFall && (bitCnt_r == BITS_PER_BYTE);
  assign byteStore = byteDone && !addrPhase_r;
  assign loadTx    = busActive && sclFall &&
                     (((state_r == ST_ACK) && rwRead_r) || (state_r == ST_NEXT));

  // ==========================================================================
  // Byte engine
  // ==========================================================================
  // One machine walks address, ack, receive and send phases.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r     <= ST_IDLE;
      rxReg_r     <= BYTE_RST;
      txReg_r     <= BYTE_RST;
      bitCnt_r    <= 4'h0;
      addrPhase_r <= 1'b0;
      rwRead_r    <= 1'b0;
      firstByte_r <= 1'b0;
      blockSel_r  <= 1'b0;
      writeSeen_r <= 1'b0;
      sdaOe_r     <= 1'b0;
    end else if (busy_r) begin
      state_r     <= ST_IDLE;                 // Deaf and released while programming. [R12]
      sdaOe_r     <= 1'b0;                    // [R12]
      writeSeen_r <= 1'b0;
    end else if (startDet) begin
      state_r     <= ST_RECV;                 // First byte is the slave address. [R1] [R15]
      addrPhase_r <= 1'b1;
      bitCnt_r    <= 4'h0;
      sdaOe_r     <= 1'b0;
    end else if (stopDet) begin
      state_r     <= ST_IDLE;
      sdaOe_r     <= 1'b0;
      writeSeen_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sdaOe_r <= 1'b0;                    // Nothing is answered before a start. [R15] [R17]
        end
        ST_RECV: begin
          if (sclRise) begin
            rxReg_r  <= {rxReg_r[6:0], sdaF};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (byteDone && addrPhase_r) begin
            addrPhase_r <= 1'b0;
            if (addrMatch(rxReg_r, pinSync_r[1], pinSync_r[0])) begin  // [R2] [R3]
              state_r     <= ST_ACK;
              sdaOe_r     <= 1'b1;                                   // [R6] [R15]
              rwRead_r    <= (rxReg_r[DIR_BIT] == DIR_READ);         // [R5]
              blockSel_r  <= rxReg_r[BLOCK_BIT];                     // [R4]
              firstByte_r <= 1'b1;                                   // [R16]
            end else begin
              state_r <= ST_IDLE;                                    // [R17]
            end
          end else if (byteStore) begin
            if (pushCh.ready) begin
              state_r     <= ST_ACK;
              sdaOe_r     <= 1'b1;            // Each written byte is acknowledged. [R8] [R15]
              firstByte_r <= 1'b0;
              writeSeen_r <= writeSeen_r | ~firstByte_r;
            end else begin
              state_r <= ST_IDLE;             // Full buffer: withhold the acknowledge. [R8]
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCnt_r <= 4'h0;
            if (rwRead_r) begin
              txReg_r <= readData;
              sdaOe_r <= ~readData[7];
              state_r <= ST_SEND;
            end else begin
              sdaOe_r <= 1'b0;                // Release after the ninth clock. [R6]
              state_r <= ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (sclRise) begin
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_r == BITS_PER_BYTE) begin
              sdaOe_r <= 1'b0;                // Release for the master's answer. [R7]
              state_r <= ST_MACK;
            end else begin
              txReg_r <= {txReg_r[6:0], 1'b0};
              sdaOe_r <= ~txReg_r[6];
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            state_r <= sdaF ? ST_IDLE : ST_NEXT;   // No acknowledge ends the read. [R7] [R8]
          end
        end
        ST_NEXT: begin
          if (sclFall) begin
            txReg_r  <= readData;
            sdaOe_r  <= ~readData[7];
            bitCnt_r <= 4'h0;
            state_r  <= ST_SEND;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          sdaOe_r <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only a low is driven, so the level is constant.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sdaOut_r     <= 1'b0;
      readStrobe_r <= 1'b0;
    end else begin
      sdaOut_r     <= 1'b0;
      readStrobe_r <= loadTx;                 // One pulse per byte taken for sending.
    end
  end

  // ==========================================================================
  // Internal write cycle
  // ==========================================================================
  // Only a stop after a data byte starts programming.
  assign commitGo = stopDet && writeSeen_r && !busy_r;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy_r    <= 1'b0;
      wrTimer_r <= '0;
    end else if (commitGo) begin
      busy_r    <= 1'b1;                                            // [R11]
      wrTimer_r <= pinSync_r[3] ? WR_TIMER_W'(WR_LO_CYCLES - 1)
                                : WR_TIMER_W'(WR_HI_CYCLES - 1);    // [R11]
    end else if (busy_r) begin
      if (wrTimer_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        wrTimer_r <= wrTimer_r - WR_TIMER_W'(1);
      end
    end
  end

  // The commit marker waits for room, so a full buffer cannot lose it.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      commitPend_r <= 1'b0;
    end else if (commitGo) begin
      commitPend_r <= 1'b1;
    end else if (pushCh.ready) begin
      commitPend_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Stream to the memory core
  // ==========================================================================
  assign pushCh.valid = (byteStore && pushCh.ready) || commitPend_r;
  assign pushCh.data  = commitPend_r ? {TAG_COMMIT, blockSel_r, BYTE_RST}
                                     : {(firstByte_r ? TAG_ADDR : TAG_DATA), blockSel_r, rxReg_r};

  // Reset release reaches the link domain through two flops.
  always_ff @(posedge linkClk) begin
    linkRst1_r <= rstn;
    linkRst2_r <= linkRst1_r;
  end

  ee_cdc_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) uFifo (
    .wclk     (mclk),
    .wrstn    (rstn),
    .push     (pushCh.snk),
    .rclk     (linkClk),
    .rrstn    (linkRst2_r),
    .outValid (linkValid),
    .outReady (linkReady),
    .outData  (linkData)
  );

endmodule // ee_slave_top

// ===== rtl/ee_pkg.sv
// Shared constants and types for the two-wire memory slave front end.
package ee_pkg;

  // ==========================================================================
  // Clock rate and derived timing
  // ==========================================================================
  localparam int CLK_FREQ_MHZ    = 200;
  // Filter widths, standard and fast speed.
  localparam int FILTER_STD_NS   = 100;
  localparam int FILTER_FAST_NS  = 50;
  // A least time, so the cycle count rounds up.
  localparam int FILTER_STD_CYC  = (FILTER_STD_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int FILTER_FAST_CYC = (FILTER_FAST_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int FILTER_CNT_W    = 5;
  // Write cycle time, high and low supply.
  localparam int WRCYC_HI_MS     = 10;
  localparam int WRCYC_LO_MS     = 15;
  localparam int WRCYC_HI_CYC    = WRCYC_HI_MS * CLK_FREQ_MHZ * 1000;
  localparam int WRCYC_LO_CYC    = WRCYC_LO_MS * CLK_FREQ_MHZ * 1000;
  localparam int WR_TIMER_W      = 22;

  // ==========================================================================
  // Slave address byte layout
  // ==========================================================================
  localparam int TYPE_MSB        = 7;
  localparam int TYPE_LSB        = 4;
  localparam int SEL_HIGH_BIT    = 3;
  localparam int SEL_LOW_BIT     = 2;
  localparam int BLOCK_BIT       = 1;
  localparam int DIR_BIT         = 0;
  localparam logic DIR_READ      = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================================
  // Stream words handed to the memory core
  // ==========================================================================
  localparam logic [1:0] TAG_DATA   = 2'h0;
  localparam logic [1:0] TAG_ADDR   = 2'h1;
  localparam logic [1:0] TAG_COMMIT = 2'h2;
  localparam int WORD_W          = 11;
  localparam int FIFO_DEPTH      = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic BUS_IDLE_LVL  = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h2,
    ST_SEND = 3'h3,
    ST_MACK = 3'h4,
    ST_NEXT = 3'h5
  } ee_state_e;

endpackage

// ===== rtl/ee_push_if.sv
// Valid/ready push channel carrying stream words between design modules.
`timescale 1ns/100ps
interface ee_push_if #(parameter int W = 11);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/ee_glitch_filter.sv
// Synchroniser and pulse filter for one bus pin.
`timescale 1ns/100ps
module ee_glitch_filter import ee_pkg::*; (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pinIn,
  input  wire logic fastMode,
  output logic      lvl_r
);
  logic                    meta_r;
  logic                    sync_r;
  logic [FILTER_CNT_W-1:0] cnt_r;
  logic [FILTER_CNT_W-1:0] limit;

  // ==========================================================================
  // Synchroniser
  // ==========================================================================
  // The first flop feeds only the second one.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= BUS_IDLE_LVL;
      sync_r <= BUS_IDLE_LVL;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
    end
  end

  // ==========================================================================
  // Filter
  // ==========================================================================
  // A level is taken once it has held for the filter width.
  assign limit = fastMode ? FILTER_CNT_W'(FILTER_FAST_CYC) : FILTER_CNT_W'(FILTER_STD_CYC);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      lvl_r <= BUS_IDLE_LVL;
    end else if (sync_r == lvl_r) begin
      cnt_r <= '0;                       // Short pulses restart the count. [R13]
    end else if (cnt_r >= limit - FILTER_CNT_W'(1)) begin
      cnt_r <= '0;
      lvl_r <= sync_r;                   // [R13]
    end else begin
      cnt_r <= cnt_r + FILTER_CNT_W'(1);
    end
  end
endmodule // ee_glitch_filter

// ===== rtl/ee_cdc_fifo.sv
// Dual-clock FIFO with gray pointers.
`timescale 1ns/100ps
module ee_cdc_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 8
)(
  input  wire logic  wclk,
  input  wire logic  wrstn,
  ee_push_if.snk     push,
  input  wire logic  rclk,
  input  wire logic  rrstn,
  output logic       outValid,
  input  wire logic  outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_r, wgray_r, rbin_r, rgray_r;
  logic [AW:0]  rgMeta_r, rgSync_r, wgMeta_r, wgSync_r;
  logic         full, empty, doPop;

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // ==========================================================================
  // Write side
  // ==========================================================================
  // Full: read pointer with its two top bits turned.
  assign full = (wgray_r == {~rgSync_r[AW:AW-1], rgSync_r[AW-2:0]});
  assign push.ready = ~full;

  always_ff @(posedge wclk) begin
    if (!wrstn) begin
      wbin_r   <= '0;
      wgray_r  <= '0;
      rgMeta_r <= '0;
      rgSync_r <= '0;
    end else begin
      rgMeta_r <= rgray_r;
      rgSync_r <= rgMeta_r;
      if (push.valid && !full) begin
        wbin_r  <= wbin_r + 1'b1;
        wgray_r <= toGray(wbin_r + 1'b1);
      end
    end
  end

  always_ff @(posedge wclk) begin
    if (push.valid && !full) begin
      mem[wbin_r[AW-1:0]] <= push.data;
    end
  end

  // ==========================================================================
  // Read side
  // ==========================================================================
  // Output register refills when empty or taken.
  assign empty = (rgray_r == wgSync_r);
  assign doPop = !empty && (!outValid || outReady);

  always_ff @(posedge rclk) begin
    if (!rrstn) begin
      rbin_r   <= '0;
      rgray_r  <= '0;
      wgMeta_r <= '0;
      wgSync_r <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      wgMeta_r <= wgray_r;
      wgSync_r <= wgMeta_r;
      if (doPop) begin
        outData  <= mem[rbin_r[AW-1:0]];
        outValid <= 1'b1;
        rbin_r   <= rbin_r + 1'b1;
        rgray_r  <= toGray(rbin_r + 1'b1);
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end
endmodule // ee_cdc_fifo

// ===== test/ee_slave_top_chk.sv
// Port assertions for the two-wire slave.
`timescale 1ns/100ps
module ee_slave_top_chk import ee_pkg::*; #(
  parameter int unsigned WR_HI_CYCLES = WRCYC_HI_CYC,
  parameter int unsigned WR_LO_CYCLES = WRCYC_LO_CYC,
  parameter int          FIFO_W       = WORD_W
)(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              linkClk,
  input wire logic              sclPin,
  input wire logic              sdaPin,
  input wire logic              sdaOut,
  input wire logic              sdaOe,
  input wire logic              writeCycleBusy,
  input wire logic              readStrobe,
  input wire logic              linkValid,
  input wire logic              linkReady,
  input wire logic [FIFO_W-1:0] linkData
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // Lockout cycles; the old count is seen at the fall.
  int unsigned busyLen_r;
  always_ff @(posedge mclk) begin
    if (!rstn || !writeCycleBusy) busyLen_r <= 0;
    else busyLen_r <= busyLen_r + 1;
  end
  sequence busStop_s;
    sclPin && sdaPin;
  endsequence
  sequence linkHeld_s;
    linkValid && $stable(linkData);
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  od_low_a: assert property (@(posedge mclk) disable iff (!rstn) sdaOut == 1'h0)
    else $error("data level high");
  sda_edge_low_a: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(sdaOe) |-> !sclPin) else $error("drive moved, clock high");
  strobe_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
    readStrobe |-> !sclPin ##1 !readStrobe) else $error("bad strobe");
  busy_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
    writeCycleBusy |-> !sdaOe) else $error("driven while busy");
  busy_max_a: assert property (@(posedge mclk) disable iff (!rstn)
    busyLen_r <= WR_LO_CYCLES) else $error("busy too long");
  busy_len_a: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(writeCycleBusy) |-> busyLen_r == WR_HI_CYCLES || busyLen_r == WR_LO_CYCLES)
    else $error("busy length");
  busy_at_stop_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(writeCycleBusy) |-> busStop_s) else $error("busy without stop");
  link_hold_a: assert property (@(posedge linkClk) disable iff (!rstn)
    linkValid && !linkReady |=> linkHeld_s) else $error("link word lost");
endmodule // ee_slave_top_chk

bind ee_slave_top ee_slave_top_chk #(.WR_HI_CYCLES(WR_HI_CYCLES),
  .WR_LO_CYCLES(WR_LO_CYCLES), .FIFO_W(FIFO_W)) i_ee_slave_top_chk (.mclk(mclk),
  .rstn(rstn), .linkClk(linkClk), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .writeCycleBusy(writeCycleBusy), .readStrobe(readStrobe),
  .linkValid(linkValid), .linkReady(linkReady), .linkData(linkData));

// ===== test/ee_bus_master.sv
// Behavioural two-wire bus master.
`timescale 1ns/100ps
module ee_bus_master #(
  parameter int H = 100
)(
  input  wire logic mclk,
  input  wire logic devOe,
  output logic      sclPin,
  output logic      sdaPin
);
  // ==========================================================================
  // Wire and bit timing
  // ==========================================================================
  logic mstOe = 1'h0;
  // Released data floats high.
  assign sdaPin = ~(mstOe | devOe);
  initial sclPin = 1'h1;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Data moves only while the clock is low.
  task automatic bitx(input logic drv, output logic smp);
    mstOe <= drv;
    tick(H / 2);
    sclPin <= 1'h1;
    tick(H / 2);
    smp = sdaPin;
    tick(H / 2);
    sclPin <= 1'h0;
    tick(H / 2);
  endtask
  task automatic start();
    mstOe <= 1'h1;
    tick(H);
    sclPin <= 1'h0;
    tick(H / 2);
  endtask
  task automatic stop();
    mstOe <= 1'h1;
    tick(H / 2);
    sclPin <= 1'h1;
    tick(H);
    mstOe <= 1'h0;
    tick(2 * H);
  endtask
  // MSB first, then release and sample.
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(~b[i], s);
    bitx(1'h0, s);
    ack = (s === 1'h0);
  endtask
  // A reader ends by withholding its acknowledge.
  task automatic recvByte(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'h0, s);
      b[i] = s;
    end
    bitx(ackIt, s);
  endtask
endmodule // ee_bus_master

// ===== test/ee_slave_top_tb_top.sv
// Self-checking bench for the two-wire slave.
`timescale 1ns/100ps
module ee_slave_top_tb_top import ee_pkg::*;;
  localparam logic [3:0] TC = 4'h5; // Arbitrary type code.
  localparam int HI = 4000;
  localparam int LO = 5000;
  logic        mclk = 1'h0, rstn = 1'h0, linkClk = 1'h0, sH = 1'h1, sL = 1'h0;
  logic        fastMode = 1'h0, lowSup = 1'h0, linkReady = 1'h1;
  logic [7:0]  rdData = 8'hC3;
  logic        sclPin, sdaPin, sdaOut, sdaOe, busy, rdStb, linkValid;
  logic [10:0] linkData;
  logic [10:0] words [$];
  int          error_cnt = 0, num_checks = 0, cyc = 0, strobes = 0, busyCnt = 0, busyLen = 0;
  // ==========================================================================
  // Clocks, design and bus master
  // ==========================================================================
  initial forever #2.5 mclk = ~mclk;
  // Offset so link edges never meet mclk edges.
  initial begin
    #3.1;
    forever #7.5 linkClk = ~linkClk;
  end
  ee_slave_top #(.TYPE_CODE(TC), .WR_HI_CYCLES(HI), .WR_LO_CYCLES(LO)) i_ee_slave_top (
    .mclk(mclk), .rstn(rstn), .linkClk(linkClk), .sclPin(sclPin), .sdaPin(sdaPin),
    .strapSelectLow(sL), .strapSelectHigh(sH), .fastModePin(fastMode),
    .lowSupplyPin(lowSup), .readData(rdData), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .writeCycleBusy(busy), .readStrobe(rdStb), .linkValid(linkValid),
    .linkReady(linkReady), .linkData(linkData));
  ee_bus_master i_ee_bus_master (.mclk(mclk), .devOe(sdaOe), .sclPin(sclPin),
    .sdaPin(sdaPin));
  // Lockout length, read strobes and the run ceiling.
  always @(posedge mclk) begin
    cyc++;
    if (busy === 1'h1) busyCnt++;
    else if (busyCnt != 0) begin
      busyLen = busyCnt;
      busyCnt = 0;
    end
    if (rdStb === 1'h1) begin
      strobes++;
      rdData <= ~rdData;
    end
    if (cyc == 90000) begin
      error_cnt++;
      conclude();
    end
  end
  // Collects every word the link consumer takes.
  always @(posedge linkClk) if (linkValid && linkReady) words.push_back(linkData);
  // ==========================================================================
  // Compare and close
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_write(input logic low);
    logic       a;
    logic [7:0] arr;
    arr = low ? 8'h3C : 8'hFF;
    words.delete();
    lowSup <= low;
    i_ee_bus_master.start();
    i_ee_bus_master.sendByte({TC, sH, sL, low, 1'h0}, a);
    chk("wr ack", 1'h1, a);
    i_ee_bus_master.sendByte(arr, a);
    chk("arr ack", 1'h1, a);
    i_ee_bus_master.sendByte(8'hA5, a);
    chk("data ack", 1'h1, a);
    i_ee_bus_master.stop();
    chk("busy", 1'h1, busy);
    i_ee_bus_master.start();
    i_ee_bus_master.sendByte({TC, sH, sL, low, 1'h0}, a);
    chk("busy ack", 1'h0, a);
    i_ee_bus_master.stop();
    for (int i = 0; i < 6000 && busy !== 1'h0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    chk("busy len", low ? LO : HI, busyLen);
    chk("words", 3, words.size());
    chk("arr word", {TAG_ADDR, low, arr}, words[0]);
    chk("data word", {TAG_DATA, low, 8'hA5}, words[1]);
    chk("commit", TAG_COMMIT, words[2][10:9]);
    $display("test_write done");
  endtask
  task automatic test_mismatch();
    logic       a;
    logic [7:0] bad [3];
    bad = '{{4'h6, sH, sL, 2'h0}, {TC, ~sH, sL, 2'h0}, {TC, sH, ~sL, 2'h0}};
    foreach (bad[i]) begin
      i_ee_bus_master.start();
      i_ee_bus_master.sendByte(bad[i], a);
      chk("bad ack", 1'h0, a);
      i_ee_bus_master.sendByte(8'h00, a);
      chk("ign ack", 1'h0, a);
      i_ee_bus_master.stop();
    end
    $display("test_mismatch done");
  endtask
  task automatic test_read();
    logic       a;
    logic [7:0] b0, b1;
    fastMode <= 1'h1;
    strobes = 0;
    i_ee_bus_master.start();
    i_ee_bus_master.sendByte({TC, sH, sL, 2'h1}, a);
    chk("rd ack", 1'h1, a);
    i_ee_bus_master.recvByte(1'h1, b0);
    i_ee_bus_master.recvByte(1'h0, b1);
    i_ee_bus_master.stop();
    chk("rd 0", 8'hC3, b0);
    chk("rd 1", 8'h3C, b1);
    chk("strobes", 2, strobes);
    chk("rd busy", 1'h0, busy);
    fastMode <= 1'h0;
    $display("test_read done");
  endtask
  // The consumer stalls until a byte is refused, then drains.
  task automatic test_fill();
    logic       a;
    logic [7:0] v;
    int         n;
    n = 0;
    a = 1'h1;
    words.delete();
    @(posedge linkClk) linkReady <= 1'h0;
    i_ee_bus_master.start();
    i_ee_bus_master.sendByte({TC, sH, sL, 2'h0}, a);
    while (a === 1'h1 && n < 12) begin
      v = 8'h10 + n[7:0];
      i_ee_bus_master.sendByte(v, a);
      if (a === 1'h1) n++;
    end
    i_ee_bus_master.stop();
    chk("refused", 1'h0, a);
    chk("depth", 1'h1, n >= FIFO_DEPTH);
    @(posedge linkClk) linkReady <= 1'h1;
    repeat (40) @(posedge linkClk);
    for (int i = 0; i < n; i++) begin
      chk("fill", {i == 0 ? TAG_ADDR : TAG_DATA, 1'h0, 8'h10 + i[7:0]}, words[i]);
    end
    $display("test_fill done");
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    chk("reset", 4'h0, {sdaOe, sdaOut, busy, rdStb});
    rstn <= 1'h1;
    repeat (8) @(posedge mclk);
    test_write(1'h0);
    test_write(1'h1);
    test_mismatch();
    test_read();
    test_fill();
    conclude();
  end
endmodule // ee_slave_top_tb_top
